/* hdl/otgs_defs.svh */
`ifndef OTGS_DEFS_SVH
`define OTGS_DEFS_SVH

// Register byte offsets
`define OTGS_OFS_CTRL 32'h0000_0000
`define OTGS_OFS_RISE 32'h0000_0004
`define OTGS_OFS_FALL 32'h0000_0008
`define OTGS_OFS_STAT 32'h0000_000C
`define OTGS_OFS_ACC 32'h0000_0010
`define OTGS_OFS_RID 32'h0000_0014

// Select positions inside the one-hot decode
`define OTGS_SEL_CTRL 0
`define OTGS_SEL_RISE 1
`define OTGS_SEL_FALL 2
`define OTGS_SEL_STAT 3
`define OTGS_SEL_ACC 4
`define OTGS_SEL_RID 5

// Field positions of the flag, enable and status words
`define OTGS_BIT_PULLUP 0
`define OTGS_BIT_BUSPWR 1
`define OTGS_BIT_SESSION_VALID_FLAG 2
`define OTGS_BIT_SESSION_END_FLAG 3
`define OTGS_BIT_IDENT_GROUNDED_FLAG 4
`define OTGS_BIT_IDENT_FLOATING_FLAG 5
`define OTGS_BIT_ACC_FLOAT 0

// Reset values
`define OTGS_CTRL_RST 1'h0
`define OTGS_EN_RST 6'h1E
`define OTGS_RID_RST 3'h5
`define OTGS_WEAK_RST 1'h1

// Bus answers
`define OTGS_RESP_OKAY 2'h0
`define OTGS_RESP_SLVERR 2'h2

`endif

/* hdl/otgs_pkg.sv */
package otgs_pkg;

  // Master side of the register bus
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } otgs_axil_req_type;

  // Slave side of the register bus
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } otgs_axil_rsp_type;

  // Comparator and converter outputs of the front end
  typedef struct packed {
    logic ident_pin_low;
    logic ident_float_cmp;
    logic [5:0] res_hit;
    logic bus_power_cmp;
    logic session_valid_cmp;
    logic session_end_cmp;
  } otgs_sense_type;

  // Receive command event toward the link
  typedef struct packed {
    logic valid;
    logic alt_int;
    logic [5:0] src;
  } otgs_event_type;

  // Bus channel states
  typedef enum logic [1:0] {
    OTGS_CH_IDLE = 2'b01,
    OTGS_CH_RESP = 2'b10
  } otgs_ch_state_type;

endpackage : otgs_pkg

/* hdl/otgs_status.sv */
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "otgs_defs.svh"
module otgs_status
  import otgs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire otgs_axil_req_type axil_req,
  output otgs_axil_rsp_type axil_rsp,
  // Front end sense inputs
  input wire otgs_sense_type sense,
  // Front end controls
  output logic ident_pin_pullup_en,
  output logic ident_weak_pullup,
  output logic bus_power_cmp_en,
  output logic session_end_cmp_en,
  // Receive command events
  output otgs_event_type evt
);

  // Bus response flops
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  // Captured write request
  logic [31:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  // Channel states
  otgs_ch_state_type wr_state_reg;
  otgs_ch_state_type rd_state_reg;
  // Software controls
  logic pullup_reg;
  logic [5:0] rise_en_reg;
  logic [5:0] fall_en_reg;
  // Comparator enables
  logic bus_cmp_en_reg;
  logic end_cmp_en_reg;
  logic weak_reg;
  // Live flags and their previous values
  logic [5:0] flag_reg;
  logic [5:0] prev_reg;
  logic seen_reg; // First flag sample taken
  logic primed_reg;
  // Resistance code
  logic [2:0] rid_code_reg;
  // Event output flops
  logic evt_valid_reg;
  logic evt_alt_reg;
  logic [5:0] evt_src_reg;
  // Handshake terms
  logic aw_fire;
  logic w_fire;
  logic b_fire;
  logic ar_fire;
  logic r_fire;
  logic wr_do;
  logic [5:0] wr_sel;
  logic [5:0] rd_sel;
  logic [5:0] edge_ev;

  // One-hot register decode, shared by both channels
  function automatic logic [5:0] reg_hit(input logic [31:0] addr);
    logic [5:0] sel;
    sel = 6'h00;
    sel[`OTGS_SEL_CTRL] = (addr == `OTGS_OFS_CTRL);
    sel[`OTGS_SEL_RISE] = (addr == `OTGS_OFS_RISE);
    sel[`OTGS_SEL_FALL] = (addr == `OTGS_OFS_FALL);
    sel[`OTGS_SEL_STAT] = (addr == `OTGS_OFS_STAT);
    sel[`OTGS_SEL_ACC] = (addr == `OTGS_OFS_ACC);
    sel[`OTGS_SEL_RID] = (addr == `OTGS_OFS_RID);
    return sel;
  endfunction : reg_hit

  // Lowest set window wins; no window keeps the old code
  function automatic logic [2:0] rid_encode(input logic [5:0] hit,
                                            input logic [2:0] old);
    logic [2:0] code;
    code = old;
    for (int i = 5; i >= 0; i--) begin
      if (hit[i]) begin
        code = 3'(i);
      end
    end
    return code;
  endfunction : rid_encode

  // Handshakes
  assign aw_fire = axil_req.awvalid & awready_reg;
  assign w_fire = axil_req.wvalid & wready_reg;
  assign b_fire = bvalid_reg & axil_req.bready;
  assign ar_fire = axil_req.arvalid & arready_reg;
  assign r_fire = rvalid_reg & axil_req.rready;
  // Write goes ahead once address and data are both held
  assign wr_do = (wr_state_reg == OTGS_CH_IDLE) & ~awready_reg & ~wready_reg;
  assign wr_sel = reg_hit(waddr_reg);
  assign rd_sel = reg_hit(axil_req.araddr);

  // Outputs straight from flops
  assign axil_rsp = '{awready: awready_reg, wready: wready_reg,
                      bvalid: bvalid_reg, bresp: bresp_reg,
                      arready: arready_reg, rvalid: rvalid_reg,
                      rdata: rdata_reg, rresp: rresp_reg};
  assign ident_pin_pullup_en = pullup_reg;
  assign ident_weak_pullup = weak_reg;
  assign bus_power_cmp_en = bus_cmp_en_reg;
  assign session_end_cmp_en = end_cmp_en_reg;
  assign evt = '{valid: evt_valid_reg, alt_int: evt_alt_reg, src: evt_src_reg};

  // Write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      waddr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      // Address taken
      if (aw_fire) begin
        awready_reg <= 1'b0;
        waddr_reg <= axil_req.awaddr;
      end
      // Data taken
      if (w_fire) begin
        wready_reg <= 1'b0;
        wdata_reg <= axil_req.wdata;
        wstrb_reg <= axil_req.wstrb;
      end
      // Reopen both after the response
      if (b_fire) begin
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Write response state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= OTGS_CH_IDLE;
      bvalid_reg <= 1'b0;
      bresp_reg <= `OTGS_RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        // Wait for both halves
        OTGS_CH_IDLE: begin
          if (wr_do) begin
            wr_state_reg <= OTGS_CH_RESP;
            bvalid_reg <= 1'b1;
            bresp_reg <= (|wr_sel) ? `OTGS_RESP_OKAY : `OTGS_RESP_SLVERR;
          end
        end
        // Hold the answer until taken
        OTGS_CH_RESP: begin
          if (b_fire) begin
            wr_state_reg <= OTGS_CH_IDLE;
            bvalid_reg <= 1'b0;
          end
        end
        // Illegal code falls back to idle
        default: begin
          wr_state_reg <= OTGS_CH_IDLE;
          bvalid_reg <= 1'b0;
        end
      endcase
    end
  end

  // Read channel state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= OTGS_CH_IDLE;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `OTGS_RESP_OKAY;
    end else begin
      unique case (rd_state_reg)
        // Take an address and load the data word
        OTGS_CH_IDLE: begin
          if (ar_fire) begin
            rd_state_reg <= OTGS_CH_RESP;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= (|rd_sel) ? `OTGS_RESP_OKAY : `OTGS_RESP_SLVERR;
            rdata_reg <= 32'h0000_0000;
            if (rd_sel[`OTGS_SEL_CTRL]) begin
              rdata_reg[`OTGS_BIT_PULLUP] <= pullup_reg;
            end
            if (rd_sel[`OTGS_SEL_RISE]) begin
              rdata_reg[5:0] <= rise_en_reg;
            end
            if (rd_sel[`OTGS_SEL_FALL]) begin
              rdata_reg[5:0] <= fall_en_reg;
            end
            // Live comparator states and grounded flag
            if (rd_sel[`OTGS_SEL_STAT]) begin
              rdata_reg[4:1] <= flag_reg[4:1];
            end
            // Floating flag in the accessory word
            if (rd_sel[`OTGS_SEL_ACC]) begin
              rdata_reg[`OTGS_BIT_ACC_FLOAT] <= flag_reg[`OTGS_BIT_IDENT_FLOATING_FLAG];
            end
            // Resistance code, readable at any time
            if (rd_sel[`OTGS_SEL_RID]) begin
              rdata_reg[2:0] <= rid_code_reg;
            end
          end
        end
        // Hold data until taken
        OTGS_CH_RESP: begin
          if (r_fire) begin
            rd_state_reg <= OTGS_CH_IDLE;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
          end
        end
        // Illegal code falls back to idle
        default: begin
          rd_state_reg <= OTGS_CH_IDLE;
          arready_reg <= 1'b1;
          rvalid_reg <= 1'b0;
        end
      endcase
    end
  end

  // Software control registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pullup_reg <= `OTGS_CTRL_RST;
      rise_en_reg <= `OTGS_EN_RST;
      fall_en_reg <= `OTGS_EN_RST;
    end else if (wr_do && wstrb_reg[0]) begin
      if (wr_sel[`OTGS_SEL_CTRL]) begin
        pullup_reg <= wdata_reg[`OTGS_BIT_PULLUP];
      end
      if (wr_sel[`OTGS_SEL_RISE]) begin
        rise_en_reg <= {wdata_reg[5:1], 1'b0};
      end
      if (wr_sel[`OTGS_SEL_FALL]) begin
        fall_en_reg <= {wdata_reg[5:1], 1'b0};
      end
    end
  end

  // Comparator power follows the enable pairs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_cmp_en_reg <= 1'b0;
      end_cmp_en_reg <= 1'b0;
      weak_reg <= `OTGS_WEAK_RST;
    end else begin
      bus_cmp_en_reg <= rise_en_reg[`OTGS_BIT_BUSPWR] | fall_en_reg[`OTGS_BIT_BUSPWR];
      end_cmp_en_reg <= rise_en_reg[`OTGS_BIT_SESSION_END_FLAG] | fall_en_reg[`OTGS_BIT_SESSION_END_FLAG];
      // Weak pull-up keeps the pin defined
      weak_reg <= 1'b1;
    end
  end

  // Live flag sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 6'h00;
    end else begin
      flag_reg[0] <= 1'b0;
      // Disabled comparator reads 0
      flag_reg[`OTGS_BIT_BUSPWR] <= sense.bus_power_cmp & bus_cmp_en_reg;
      // One comparator for both roles, never gated
      flag_reg[`OTGS_BIT_SESSION_VALID_FLAG] <= sense.session_valid_cmp;
      // Rises when Vbus drops under the end threshold
      flag_reg[`OTGS_BIT_SESSION_END_FLAG] <= sense.session_end_cmp & end_cmp_en_reg;
      // Low pin means an A cable: flag reads 0
      flag_reg[`OTGS_BIT_IDENT_GROUNDED_FLAG] <= ~sense.ident_pin_low;
      flag_reg[`OTGS_BIT_IDENT_FLOATING_FLAG] <= sense.ident_float_cmp;
    end
  end

  // Resistance code, converted while the strong pull-up is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rid_code_reg <= `OTGS_RID_RST;
    end else if (!pullup_reg) begin
      rid_code_reg <= rid_encode(sense.res_hit, rid_code_reg);
    end
  end

  // Previous flags; edges count only once prev_reg holds a real sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 6'h00;
      seen_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= flag_reg;
      // Avoids a false grounded-flag rise against the reset zeros
      seen_reg <= 1'b1;
      primed_reg <= seen_reg;
    end
  end

  // Per flag edge detection under its own enables
  generate
    for (genvar i = 0; i < 6; i++) begin : g_edge
      assign edge_ev[i] = primed_reg &
        ((flag_reg[i] & ~prev_reg[i] & rise_en_reg[i]) |
         (~flag_reg[i] & prev_reg[i] & fall_en_reg[i]));
    end
  endgenerate

  // Event pulse toward the link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_valid_reg <= 1'b0;
      evt_alt_reg <= 1'b0;
      evt_src_reg <= 6'h00;
    end else begin
      // Ground attach shows as a grounded flag fall
      evt_valid_reg <= |edge_ev;
      // Floating change carries the alternate bit
      evt_alt_reg <= edge_ev[`OTGS_BIT_IDENT_FLOATING_FLAG];
      evt_src_reg <= edge_ev;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_gnd_pol;
    sense.ident_pin_low |=> !flag_reg[`OTGS_BIT_IDENT_GROUNDED_FLAG];
  endproperty
  a_gnd_pol: assert property (p_gnd_pol) else $error("grounded flag polarity");

  property p_gnd_event;
    primed_reg && !sense.ident_pin_low && fall_en_reg[`OTGS_BIT_IDENT_GROUNDED_FLAG]
      ##1 sense.ident_pin_low && fall_en_reg[`OTGS_BIT_IDENT_GROUNDED_FLAG] |=> ##1 evt_valid_reg;
  endproperty
  a_gnd_event: assert property (p_gnd_event) else $error("no ground event");

  property p_rid_code;
    !pullup_reg && sense.res_hit == 6'h04 |=> rid_code_reg == 3'h2;
  endproperty
  a_rid_code: assert property (p_rid_code) else $error("resistance code wrong");

  property p_rid_read;
    ar_fire && rd_sel[`OTGS_SEL_RID] |=> rvalid_reg && rdata_reg[2:0] == $past(rid_code_reg);
  endproperty
  a_rid_read: assert property (p_rid_read) else $error("code read wrong");

  property p_alt_int;
    edge_ev[`OTGS_BIT_IDENT_FLOATING_FLAG] |=> evt_valid_reg && evt_alt_reg;
  endproperty
  a_alt_int: assert property (p_alt_int) else $error("alternate bit missing");

  property p_float;
    1'b1 |=> flag_reg[`OTGS_BIT_IDENT_FLOATING_FLAG] == $past(sense.ident_float_cmp);
  endproperty
  a_float: assert property (p_float) else $error("floating flag wrong");

  property p_stat_read;
    ar_fire && rd_sel[`OTGS_SEL_STAT] |=> rdata_reg[4] == $past(flag_reg[4]);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status bit 4 wrong");

  property p_end_off;
    !(rise_en_reg[3] | fall_en_reg[3]) [*3] |-> !flag_reg[`OTGS_BIT_SESSION_END_FLAG];
  endproperty
  a_end_off: assert property (p_end_off) else $error("session end not off");

  property p_vld_live;
    !(rise_en_reg[2] | fall_en_reg[2]) |=> flag_reg[2] == $past(sense.session_valid_cmp);
  endproperty
  a_vld_live: assert property (p_vld_live) else $error("session valid gated");

  property p_bus_off;
    !(rise_en_reg[1] | fall_en_reg[1]) [*3] |-> !flag_reg[`OTGS_BIT_BUSPWR];
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus power not off");

  property p_rise_gate;
    primed_reg && $rose(flag_reg[1]) |=> evt_src_reg[1] == $past(rise_en_reg[1]);
  endproperty
  a_rise_gate: assert property (p_rise_gate) else $error("rise gating wrong");

  c_alt: cover property (evt_valid_reg && evt_alt_reg);
  c_rid: cover property (ar_fire && rd_sel[`OTGS_SEL_RID]);
  c_wr: cover property (b_fire && bresp_reg == `OTGS_RESP_OKAY);

endmodule : otgs_status

/* testbench/otgs_link_model.sv */
`timescale 1ns/1ps
module otgs_link_model
  import otgs_pkg::*;
#(
  parameter int SETTLE_CYCLES = 8 // Shortened pull-up settle wait
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus, link as master
  output otgs_axil_req_type axil_req,
  input wire otgs_axil_rsp_type axil_rsp,
  // Receive command events
  input wire otgs_event_type evt
);
  logic hang; // An answer never came
  int evt_count; // Event pulses seen
  logic [5:0] evt_src; // Sources of the last pulse
  logic evt_alt; // Alternate flag of the last pulse

  // Idle bus from time zero
  initial begin
    axil_req = '0;
    // Answer channels always open, so no release and re-raise in one step
    axil_req.bready = 1'b1;
    axil_req.rready = 1'b1;
    hang = 1'b0;
  end

  // Capture each event pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_count <= 0;
    end else if (evt.valid) begin
      evt_count <= evt_count + 1;
      evt_src <= evt.src;
      evt_alt <= evt.alt_int;
    end
  end

  // Wait after enabling the strong pull-up before reading the pin state
  task automatic id_settle;
    begin
      repeat (SETTLE_CYCLES) @(posedge aclk);
    end
  endtask : id_settle

  // One bus access; each channel held until its own ready
  task automatic access(input logic is_wr, input logic [31:0] addr,
                        input logic [31:0] data, output logic [31:0] rdata,
                        output logic [1:0] resp);
    int n;
    logic done;
    begin
      n = 0;
      done = 1'b0;
      rdata = '0;
      resp = 2'h3;
      if (is_wr) begin
        axil_req.awaddr <= addr;
        axil_req.wdata <= data;
        axil_req.wstrb <= 4'hF;
        axil_req.awvalid <= 1'b1;
        axil_req.wvalid <= 1'b1;
      end else begin
        axil_req.araddr <= addr;
        axil_req.arvalid <= 1'b1;
      end
      // Bounded wait for the answer
      while (!done && n < 64) begin
        @(posedge aclk);
        n++;
        if (axil_req.awvalid && axil_rsp.awready) axil_req.awvalid <= 1'b0;
        if (axil_req.wvalid && axil_rsp.wready) axil_req.wvalid <= 1'b0;
        if (axil_req.arvalid && axil_rsp.arready) axil_req.arvalid <= 1'b0;
        if (is_wr && axil_rsp.bvalid) begin
          resp = axil_rsp.bresp;
          done = 1'b1;
        end
        if (!is_wr && axil_rsp.rvalid) begin
          rdata = axil_rsp.rdata;
          resp = axil_rsp.rresp;
          done = 1'b1;
        end
      end
      if (!done) hang = 1'b1;
    end
  endtask : access
endmodule : otgs_link_model

/* testbench/otgs_status_test.sv */
`timescale 1ns/1ps
`include "otgs_defs.svh"
module otgs_status_test
  import otgs_pkg::*;
;
  logic aclk; // System clock
  logic aresetn; // Synchronous reset
  otgs_axil_req_type req; // Bus requests
  otgs_axil_rsp_type rsp; // Bus answers
  otgs_sense_type sense; // Front end levels
  logic pullup_en; // Strong pull-up control
  logic weak_pullup; // Weak pull-up control
  logic bp_en; // Bus power comparator on
  logic se_en; // Session end comparator on
  otgs_event_type evt; // Event pulses
  logic [31:0] rd_data; // Last read word
  logic [1:0] resp; // Last bus answer
  int errors; // Mismatches
  int comparisons; // Comparisons made

  otgs_status otgs_status_i (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .sense(sense), .ident_pin_pullup_en(pullup_en),
    .ident_weak_pullup(weak_pullup), .bus_power_cmp_en(bp_en),
    .session_end_cmp_en(se_en), .evt(evt));

  otgs_link_model otgs_link_model_i (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .evt(evt));

  // Free running clock
  always #2 aclk = ~aclk;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    begin
      comparisons++;
      if (seen !== expected) begin
        errors++;
        $display("CHECK FAILED at %0t: seen 0x%08h expected 0x%08h", $time, seen, expected);
      end
    end
  endtask : check

  // Closing report
  task automatic give_verdict;
    begin
      errors += int'(otgs_link_model_i.hang);
      $display("Comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask : give_verdict

  // Register write, answer left in resp
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    begin
      otgs_link_model_i.access(1'b1, a, d, unused, resp);
      if (otgs_link_model_i.hang) give_verdict();
    end
  endtask : wr

  // Register read against an expected word
  task automatic rd_check(input logic [31:0] a, input logic [31:0] exp_v);
    begin
      otgs_link_model_i.access(1'b0, a, 32'h0, rd_data, resp);
      if (otgs_link_model_i.hang) give_verdict();
      check(rd_data, exp_v);
    end
  endtask : rd_check

  // Count event pulses after a sense change
  task automatic expect_events(input int n, input logic [5:0] src, input logic alt);
    int base;
    begin
      base = otgs_link_model_i.evt_count;
      repeat (6) @(posedge aclk);
      check(32'(otgs_link_model_i.evt_count - base), 32'(n));
      if (n > 0) check({25'h0, otgs_link_model_i.evt_alt, otgs_link_model_i.evt_src},
                       {25'h0, alt, src});
    end
  endtask : expect_events

  // Main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    errors = 0;
    comparisons = 0;
    sense = '0;
    sense.res_hit = 6'h20;
    sense.session_end_cmp = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset state and an unmapped place
    check(32'(weak_pullup), 32'h0000_0001);
    rd_check(`OTGS_OFS_CTRL, 32'h0000_0000);
    // Both comparators powered by the default enables
    check({30'h0, bp_en, se_en}, 32'h0000_0003);
    rd_check(`OTGS_OFS_RISE, 32'h0000_001E);
    rd_check(`OTGS_OFS_FALL, 32'h0000_001E);
    rd_check(`OTGS_OFS_RID, 32'h0000_0005);
    rd_check(`OTGS_OFS_STAT, 32'h0000_0018);
    rd_check(32'h0000_0018, 32'h0000_0000);
    check(32'(resp), 32'(`OTGS_RESP_SLVERR));
    // Cable grounds the pin with the strong pull-up off
    sense.ident_pin_low <= 1'b1;
    sense.res_hit <= 6'h01;
    expect_events(1, 6'h10, 1'b0);
    rd_check(`OTGS_OFS_STAT, 32'h0000_0008);
    rd_check(`OTGS_OFS_RID, 32'h0000_0000);
    // Remaining resistance windows, 1 to 5
    for (int i = 1; i < 6; i++) begin
      sense.res_hit <= 6'(6'h01 << i);
      repeat (2) @(posedge aclk);
      rd_check(`OTGS_OFS_RID, 32'(i));
    end
    // Float comparator method with the strong pull-up on
    wr(`OTGS_OFS_CTRL, 32'h0000_0001);
    check(32'(pullup_en), 32'h0000_0001);
    otgs_link_model_i.id_settle();
    sense.res_hit <= 6'h04;
    wr(`OTGS_OFS_RISE, 32'h0000_003E);
    wr(`OTGS_OFS_FALL, 32'h0000_003E);
    rd_check(`OTGS_OFS_RID, 32'h0000_0005);
    sense.ident_float_cmp <= 1'b1;
    expect_events(1, 6'h20, 1'b1);
    rd_check(`OTGS_OFS_ACC, 32'h0000_0001);
    sense.ident_float_cmp <= 1'b0;
    expect_events(1, 6'h20, 1'b1);
    rd_check(`OTGS_OFS_ACC, 32'h0000_0000);
    // A plug seen: strong pull-up and float edges dropped
    wr(`OTGS_OFS_CTRL, 32'h0000_0000);
    wr(`OTGS_OFS_RISE, 32'h0000_001E);
    wr(`OTGS_OFS_FALL, 32'h0000_001E);
    check(32'(pullup_en), 32'h0000_0000);
    sense.ident_float_cmp <= 1'b1;
    expect_events(0, 6'h00, 1'b0);
    // Grounded flag edges under each enable
    wr(`OTGS_OFS_RISE, 32'h0000_000E);
    sense.ident_pin_low <= 1'b0;
    expect_events(0, 6'h00, 1'b0);
    sense.ident_pin_low <= 1'b1;
    expect_events(1, 6'h10, 1'b0);
    wr(`OTGS_OFS_RISE, 32'h0000_001E);
    wr(`OTGS_OFS_FALL, 32'h0000_000E);
    sense.ident_pin_low <= 1'b0;
    expect_events(1, 6'h10, 1'b0);
    sense.ident_pin_low <= 1'b1;
    expect_events(0, 6'h00, 1'b0);
    // Session valid with its events masked stays live
    wr(`OTGS_OFS_RISE, 32'h0000_001A);
    wr(`OTGS_OFS_FALL, 32'h0000_001A);
    sense.session_valid_cmp <= 1'b1;
    expect_events(0, 6'h00, 1'b0);
    rd_check(`OTGS_OFS_STAT, 32'h0000_000C);
    // Supply present, then gone again
    sense.bus_power_cmp <= 1'b1;
    sense.session_end_cmp <= 1'b0;
    expect_events(1, 6'h0A, 1'b0);
    rd_check(`OTGS_OFS_STAT, 32'h0000_0006);
    sense.session_end_cmp <= 1'b1;
    expect_events(1, 6'h08, 1'b0);
    rd_check(`OTGS_OFS_STAT, 32'h0000_000E);
    // Comparators switched off by clearing both enables
    wr(`OTGS_OFS_RISE, 32'h0000_0010);
    wr(`OTGS_OFS_FALL, 32'h0000_0010);
    expect_events(0, 6'h00, 1'b0);
    check({30'h0, bp_en, se_en}, 32'h0000_0000);
    rd_check(`OTGS_OFS_STAT, 32'h0000_0004);
    // Writes to a status word and to an unmapped place
    wr(`OTGS_OFS_STAT, 32'h0000_00FF);
    check(32'(resp), 32'(`OTGS_RESP_OKAY));
    wr(32'h0000_0018, 32'h0000_00FF);
    check(32'(resp), 32'(`OTGS_RESP_SLVERR));
    rd_check(`OTGS_OFS_STAT, 32'h0000_0004);
    give_verdict();
  end
endmodule : otgs_status_test
